// File: tx_redund_pkg.sv
// Package: register map, field limits, reset values and carriers for the transmit redundancy controller
package tx_redund_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] ATTEN_OFF = 8'h00;
  localparam logic [7:0] START_DELAY_OFF = 8'h04;
  localparam logic [7:0] POWERUP_STATE_OFF = 8'h08;
  localparam logic [7:0] TX_ENABLE_OFF = 8'h0c;
  localparam logic [7:0] OVERTEMP_EN_OFF = 8'h10;
  localparam logic [7:0] TX_HOURS_OFF = 8'h14;
  localparam logic [7:0] TZ_OFFSET_OFF = 8'h18;
  localparam logic [7:0] REDUND_REPORT_OFF = 8'h1c;
  localparam logic [7:0] REDUND_EN_OFF = 8'h20;
  localparam logic [7:0] REVERT_MODE_OFF = 8'h24;
  localparam logic [7:0] SWITCH_PORT_OFF = 8'h28;
  localparam logic [7:0] CLONE_EN_OFF = 8'h2c;
  localparam logic [7:0] WARM_STANDBY_OFF = 8'h30;
  localparam logic [7:0] SWITCH_TYPE_OFF = 8'h34;
  localparam logic [7:0] PAIR_STATUS_OFF = 8'h38;
  localparam logic [7:0] ONLINE_SELECT_OFF = 8'h3c;
  localparam logic [7:0] PEER_ADDR_OFF = 8'h40;
  localparam logic [7:0] PEER_PUBLIC_OFF = 8'h44;
  localparam logic [7:0] ERR_STATUS_OFF = 8'h48;

  // ----------------------------------------------------------------
  // Field limits
  // ----------------------------------------------------------------
  localparam logic [7:0] ATTEN_MAX = 8'ha0;              // 16.0 dB in tenths
  localparam logic [8:0] DELAY_MAX_S = 9'h1f4;           // 500 s
  localparam logic signed [7:0] TZ_HOUR_MIN = 8'shf4;    // -12
  localparam logic signed [7:0] TZ_HOUR_MAX = 8'sh0e;    // +14
  localparam logic [5:0] TZ_MINUTE_MAX = 6'h3b;
  localparam logic signed [7:0] OVERTEMP_LIMIT_C = 8'sh55;
  localparam logic [31:0] PEER_ADDR_MIN = 32'h01000000;
  localparam logic [31:0] PEER_ADDR_MAX = 32'hdffffffe;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 32'h4;
  localparam int unsigned SEC_NS = 32'h3b9aca00;
  localparam int unsigned CYCLES_PER_SEC = SEC_NS / CLK_PERIOD_NS;
  localparam logic [11:0] SECS_PER_HOUR = 12'he10;
  localparam logic [7:0] CLONE_PERIOD_S = 8'h0a;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] ATTEN_RST = 8'h00;
  localparam logic [8:0] START_DELAY_RST = 9'h000;
  localparam logic POWERUP_STATE_RST = 1'b1;
  localparam logic OVERTEMP_EN_RST = 1'b1;
  localparam logic REDUND_EN_RST = 1'b0;
  localparam logic CLONE_EN_RST = 1'b0;
  localparam logic WARM_STANDBY_RST = 1'b0;
  localparam logic PORT_B_RST = 1'b0;
  localparam logic SWITCH_B_RST = 1'b0;
  localparam logic [31:0] PEER_ADDR_RST = 32'hc0a80116;
  localparam logic [31:0] PEER_PUBLIC_RST = 32'h00000000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic {REVERTING = 1'b0, NON_REVERTING = 1'b1} revert_mode_t;
  typedef enum logic {SW_MANUAL = 1'b0, SW_AUTO = 1'b1} switching_type_t;
  typedef enum logic [1:0] {TX_OFF = 2'h0, TX_ON = 2'h1, TX_MUTED = 2'h2} tx_report_t;

  typedef struct packed {
    revert_mode_t revert_mode;
    switching_type_t switching_type;
    logic warm_standby_enable;
    logic clone_enable;
    logic tx_valid;
    logic [8:0] tx_start_delay;
    logic powerup_tx_state;
    logic tx_output_enable;
    logic overtemp_shutdown_enable;
  } clone_msg_t;

  localparam clone_msg_t CLONE_MSG_RST = '{REVERTING, SW_AUTO, WARM_STANDBY_RST, CLONE_EN_RST, 1'b0,
                                           START_DELAY_RST, POWERUP_STATE_RST, POWERUP_STATE_RST, OVERTEMP_EN_RST};

endpackage

// File: tx_output_redundancy_control.sv
// Transmit output gating and one-plus-one redundancy controller with register port
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Overview of operation
// [RL1] Attenuation held 0.0 to 16.0 dB, tenths
// [RL2] Output muted for start delay after power-up
// [RL3] Zero start delay enables output at once
// [RL4] Stored power-up state applied on power restore
// [RL5] Host writes enable; alarms override it
// [RL6] Enable reads 0 off, 1 on, 2 muted
// [RL7] Over 85 C with shutdown enabled disables output
// [RL8] Shutdown setting 0/1, enabled by default
// [RL9] Read-only hours of unmuted enabled output
// [RL10] Signed time zone offset, hours -12 to 14
// [RL11] Report redundancy, master position and cloning
// [RL12] Reverting mode switches on every single fault
// [RL13] Non-reverting moves A to B once only
// [RL14] Stored waveguide port, does not move switch
// [RL15] Shared settings copied; changed only on master
// [RL16] Cloning sends transmit settings to offline slave
// [RL17] Warm standby keeps B standby output off
// [RL18] Manual switching only by host command
// [RL19] Automatic switching on online major fault
// [RL20] Pair status gives switching type and switch side
// [RL21] Online select drives the waveguide switch
// [RL22] Peer address stored, range checked, default set
// [RL23] Output active only enabled, delay done, no alarm
// [RL24] Bad or forbidden writes rejected, value kept
// ----------------------------------------------------------------
module tx_output_redundancy_control
  import tx_redund_pkg::*;
#(
  parameter int unsigned CYCLES_PER_SEC_P = CYCLES_PER_SEC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic signed [7:0] temp_c,
  input wire logic local_major_fault,
  input wire logic peer_major_fault_pin,
  input wire logic power_restore,
  input wire logic peer_cfg_valid,
  input wire clone_msg_t peer_cfg,
  output logic tx_output_on,
  output logic tx_muted,
  output logic switch_drive_b,
  output logic clone_valid,
  output clone_msg_t clone_msg,
  output logic [31:0] peer_address,
  output logic [31:0] peer_public_address,
  output logic cmd_reject
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] rdata;
    logic [7:0] atten;
    logic [8:0] start_delay;
    logic powerup_state;
    logic tx_en;
    logic ote;
    logic [31:0] hours;
    logic [7:0] tz_hours;
    logic [5:0] tz_minutes;
    logic redund_en;
    revert_mode_t revert;
    switching_type_t sw_type;
    logic port_b;
    logic clone_en;
    logic warm;
    logic switch_b;
    logic [31:0] peer_addr;
    logic [31:0] peer_pub;
    logic err_range;
    logic err_perm;
    logic [8:0] delay_left;
    logic [27:0] prescale;
    logic [11:0] hour_secs;
    logic [7:0] clone_secs;
    logic pf_s1;
    logic pf_s2;
    logic pf_s3;
    logic pf_filt;
    logic tx_on;
    logic muted;
    logic clone_valid;
    clone_msg_t clone_msg;
    logic reject;
  } state_t;

  localparam state_t STATE_RST = '{
    rdata: 32'h0, atten: ATTEN_RST, start_delay: START_DELAY_RST, powerup_state: POWERUP_STATE_RST,
    tx_en: POWERUP_STATE_RST, ote: OVERTEMP_EN_RST, hours: 32'h0, tz_hours: 8'h00, tz_minutes: 6'h00,
    redund_en: REDUND_EN_RST, revert: REVERTING, sw_type: SW_AUTO, port_b: PORT_B_RST,
    clone_en: CLONE_EN_RST, warm: WARM_STANDBY_RST, switch_b: SWITCH_B_RST, peer_addr: PEER_ADDR_RST,
    peer_pub: PEER_PUBLIC_RST, err_range: 1'b0, err_perm: 1'b0, delay_left: START_DELAY_RST,
    prescale: 28'h0, hour_secs: 12'h000, clone_secs: 8'h00, pf_s1: 1'b0, pf_s2: 1'b0, pf_s3: 1'b0,
    pf_filt: 1'b0, tx_on: 1'b0, muted: 1'b0, clone_valid: 1'b0, clone_msg: CLONE_MSG_RST, reject: 1'b0};

  state_t q_reg;
  state_t q_next;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic is_bit(input logic [31:0] w);
    is_bit = (w[31:1] == 31'h0);
  endfunction

  function automatic logic addr_ok(input logic [31:0] w);
    addr_ok = (w >= PEER_ADDR_MIN) && (w <= PEER_ADDR_MAX);
  endfunction

  logic online;
  logic master;
  logic overtemp_alarm;
  logic warm_off;
  logic tx_active;
  logic online_fault;
  logic standby_fault;
  logic sec_tick;

  // A unit is online when the switch points at the port it feeds
  assign online = (q_reg.switch_b == q_reg.port_b); // [RL14]
  assign master = !q_reg.redund_en || online;
  assign overtemp_alarm = q_reg.ote && (temp_c > OVERTEMP_LIMIT_C); // [RL7]
  // Warm standby only ever silences the B-port unit while it is offline
  assign warm_off = q_reg.redund_en && q_reg.warm && q_reg.port_b && !online; // [RL17]
  assign tx_active = q_reg.tx_en && (q_reg.delay_left == 9'h000) && !overtemp_alarm && !warm_off; // [RL23] [RL5]
  assign online_fault = online ? local_major_fault : q_reg.pf_filt;
  assign standby_fault = online ? q_reg.pf_filt : local_major_fault;
  assign sec_tick = (q_reg.prescale == 28'(CYCLES_PER_SEC_P - 1));

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic rng;
    logic perm;
    logic accept;
    logic [7:0] tzh;
    rng = 1'b0;
    perm = 1'b1;
    accept = 1'b0;
    tzh = reg_wdata[15:8];
    q_next = q_reg;
    q_next.rdata = 32'h0;
    q_next.reject = 1'b0;
    q_next.clone_valid = 1'b0;

    // Peer fault comes from another unit; filter it before use
    q_next.pf_s1 = peer_major_fault_pin;
    q_next.pf_s2 = q_reg.pf_s1;
    q_next.pf_s3 = q_reg.pf_s2;
    if (q_reg.pf_s2 == q_reg.pf_s3) begin
      q_next.pf_filt = q_reg.pf_s3;
    end

    q_next.prescale = sec_tick ? 28'h0 : q_reg.prescale + 28'h1;
    q_next.tx_on = tx_active;
    q_next.muted = q_reg.tx_en && !tx_active;

    if (sec_tick && (q_reg.delay_left != 9'h000)) begin
      q_next.delay_left = q_reg.delay_left - 9'h001; // [RL2]
    end

    // Seconds of live output are rolled into whole hours
    if (sec_tick && q_reg.tx_on) begin
      if (q_reg.hour_secs == SECS_PER_HOUR - 12'h001) begin
        q_next.hour_secs = 12'h000;
        q_next.hours = q_reg.hours + 32'h1; // [RL9]
      end else begin
        q_next.hour_secs = q_reg.hour_secs + 12'h001;
      end
    end

    if (power_restore) begin
      q_next.tx_en = q_reg.powerup_state; // [RL4]
      q_next.delay_left = q_reg.start_delay; // [RL2] [RL3]
    end

    // Automatic switching; a healthy standby is required in both modes
    if (q_reg.redund_en && (q_reg.sw_type == SW_AUTO) && online_fault && !standby_fault) begin // [RL19] [RL18]
      if (q_reg.revert == REVERTING) begin
        q_next.switch_b = !q_reg.switch_b; // [RL12]
      end else if (!q_reg.switch_b) begin
        q_next.switch_b = 1'b1; // [RL13]
      end
    end

    // Settings pushed by the online master land only on the offline unit
    if (peer_cfg_valid && q_reg.redund_en && !online) begin
      q_next.revert = peer_cfg.revert_mode; // [RL15]
      q_next.sw_type = peer_cfg.switching_type;
      q_next.warm = peer_cfg.warm_standby_enable;
      q_next.clone_en = peer_cfg.clone_enable;
      if (peer_cfg.tx_valid) begin
        q_next.start_delay = peer_cfg.tx_start_delay; // [RL16]
        q_next.powerup_state = peer_cfg.powerup_tx_state;
        q_next.tx_en = peer_cfg.tx_output_enable;
        q_next.ote = peer_cfg.overtemp_shutdown_enable;
      end
    end

    if (sec_tick) begin
      if (q_reg.clone_secs == CLONE_PERIOD_S - 8'h01) begin
        q_next.clone_secs = 8'h00;
        if (q_reg.redund_en && online) begin
          q_next.clone_valid = 1'b1; // [RL15] [RL16]
          q_next.clone_msg = '{q_reg.revert, q_reg.sw_type, q_reg.warm, q_reg.clone_en, q_reg.clone_en,
                               q_reg.start_delay, q_reg.powerup_state, q_reg.tx_en, q_reg.ote};
        end
      end else begin
        q_next.clone_secs = q_reg.clone_secs + 8'h01;
      end
    end

    // ----------------------------------------------------------------
    // Write checks: range first, then permission
    // ----------------------------------------------------------------
    case (reg_addr)
      ATTEN_OFF: rng = (reg_wdata <= {24'h0, ATTEN_MAX}); // [RL1]
      START_DELAY_OFF: begin
        rng = (reg_wdata <= {23'h0, DELAY_MAX_S}); // [RL2]
        perm = !(q_reg.redund_en && q_reg.clone_en && !online); // [RL16]
      end
      POWERUP_STATE_OFF, TX_ENABLE_OFF, OVERTEMP_EN_OFF: begin
        rng = is_bit(reg_wdata); // [RL8]
        perm = !(q_reg.redund_en && q_reg.clone_en && !online); // [RL16]
      end
      TZ_OFFSET_OFF: begin
        rng = (reg_wdata[31:16] == 16'h0) && (reg_wdata[7:6] == 2'h0) && (reg_wdata[5:0] <= TZ_MINUTE_MAX)
              && ($signed(tzh) >= TZ_HOUR_MIN) && ($signed(tzh) <= TZ_HOUR_MAX); // [RL10]
      end
      REDUND_EN_OFF, SWITCH_PORT_OFF: rng = is_bit(reg_wdata);
      REVERT_MODE_OFF, CLONE_EN_OFF, WARM_STANDBY_OFF, SWITCH_TYPE_OFF: begin
        rng = is_bit(reg_wdata);
        perm = master; // [RL15]
      end
      ONLINE_SELECT_OFF: begin
        rng = is_bit(reg_wdata);
        // In automatic mode the host may only swap a healthy pair
        perm = (q_reg.sw_type == SW_MANUAL) || (!local_major_fault && !q_reg.pf_filt); // [RL18]
      end
      PEER_ADDR_OFF, PEER_PUBLIC_OFF: rng = addr_ok(reg_wdata); // [RL22]
      ERR_STATUS_OFF: rng = 1'b1;
      default: rng = 1'b0;
    endcase
    accept = reg_wr && rng && perm;

    if (accept) begin
      case (reg_addr)
        ATTEN_OFF: q_next.atten = reg_wdata[7:0];
        START_DELAY_OFF: q_next.start_delay = reg_wdata[8:0];
        POWERUP_STATE_OFF: q_next.powerup_state = reg_wdata[0];
        TX_ENABLE_OFF: q_next.tx_en = reg_wdata[0]; // [RL5]
        OVERTEMP_EN_OFF: q_next.ote = reg_wdata[0];
        TZ_OFFSET_OFF: begin
          q_next.tz_hours = reg_wdata[15:8];
          q_next.tz_minutes = reg_wdata[5:0];
        end
        REDUND_EN_OFF: q_next.redund_en = reg_wdata[0];
        REVERT_MODE_OFF: q_next.revert = revert_mode_t'(reg_wdata[0]);
        SWITCH_PORT_OFF: q_next.port_b = reg_wdata[0]; // [RL14]
        CLONE_EN_OFF: q_next.clone_en = reg_wdata[0];
        WARM_STANDBY_OFF: q_next.warm = reg_wdata[0];
        SWITCH_TYPE_OFF: q_next.sw_type = switching_type_t'(reg_wdata[0]);
        ONLINE_SELECT_OFF: q_next.switch_b = reg_wdata[0]; // [RL21]
        PEER_ADDR_OFF: q_next.peer_addr = reg_wdata; // [RL22]
        PEER_PUBLIC_OFF: q_next.peer_pub = reg_wdata;
        default: q_next.peer_pub = q_next.peer_pub;
      endcase
    end

    // Sticky errors: write one to clear, a new error in the same cycle wins
    q_next.err_range = q_reg.err_range;
    q_next.err_perm = q_reg.err_perm;
    if (reg_wr && (reg_addr == ERR_STATUS_OFF)) begin
      q_next.err_range = q_reg.err_range && !reg_wdata[0];
      q_next.err_perm = q_reg.err_perm && !reg_wdata[1];
    end
    if (reg_wr && !accept) begin
      q_next.reject = 1'b1; // [RL24]
      if (!rng) begin
        q_next.err_range = 1'b1;
      end else begin
        q_next.err_perm = 1'b1;
      end
    end

    // ----------------------------------------------------------------
    // Read mux, answer in the following cycle
    // ----------------------------------------------------------------
    if (reg_rd) begin
      case (reg_addr)
        ATTEN_OFF: q_next.rdata = {24'h0, q_reg.atten};
        START_DELAY_OFF: q_next.rdata = {23'h0, q_reg.start_delay};
        POWERUP_STATE_OFF: q_next.rdata = {31'h0, q_reg.powerup_state};
        TX_ENABLE_OFF: q_next.rdata = {30'h0, !q_reg.tx_en ? TX_OFF : (q_reg.tx_on ? TX_ON : TX_MUTED)}; // [RL6]
        OVERTEMP_EN_OFF: q_next.rdata = {31'h0, q_reg.ote};
        TX_HOURS_OFF: q_next.rdata = q_reg.hours; // [RL9]
        TZ_OFFSET_OFF: q_next.rdata = {16'h0, q_reg.tz_hours, 2'h0, q_reg.tz_minutes};
        REDUND_REPORT_OFF: q_next.rdata = {29'h0, q_reg.clone_en, master, q_reg.redund_en}; // [RL11]
        REDUND_EN_OFF: q_next.rdata = {31'h0, q_reg.redund_en};
        REVERT_MODE_OFF: q_next.rdata = {31'h0, q_reg.revert};
        SWITCH_PORT_OFF: q_next.rdata = {31'h0, q_reg.port_b};
        CLONE_EN_OFF: q_next.rdata = {31'h0, q_reg.clone_en};
        WARM_STANDBY_OFF: q_next.rdata = {31'h0, q_reg.warm};
        SWITCH_TYPE_OFF: q_next.rdata = {31'h0, q_reg.sw_type};
        PAIR_STATUS_OFF: q_next.rdata = {27'h0, q_reg.switch_b, q_reg.switch_b, q_reg.sw_type,
                                         !q_reg.switch_b, q_reg.sw_type}; // [RL20]
        ONLINE_SELECT_OFF: q_next.rdata = {31'h0, q_reg.switch_b};
        PEER_ADDR_OFF: q_next.rdata = q_reg.peer_addr;
        PEER_PUBLIC_OFF: q_next.rdata = q_reg.peer_pub;
        ERR_STATUS_OFF: q_next.rdata = {30'h0, q_reg.err_perm, q_reg.err_range};
        default: q_next.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q_reg <= STATE_RST;
    end else if (ce) begin
      q_reg <= q_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata = q_reg.rdata;
  assign tx_output_on = q_reg.tx_on;
  assign tx_muted = q_reg.muted;
  assign switch_drive_b = q_reg.switch_b;
  assign clone_valid = q_reg.clone_valid;
  assign clone_msg = q_reg.clone_msg;
  assign peer_address = q_reg.peer_addr;
  assign peer_public_address = q_reg.peer_pub;
  assign cmd_reject = q_reg.reject;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  AST_ATTEN_RANGE: assert property (q_reg.atten <= ATTEN_MAX) // [RL1]
    else $error("attenuation out of range");
  AST_DELAY_MUTES: assert property (ce && (q_reg.delay_left != 9'h000) |=> !tx_output_on) // [RL2]
    else $error("output live during start delay");
  AST_ZERO_DELAY: assert property (ce && power_restore && (q_reg.start_delay == 9'h000)
                                   |=> q_reg.delay_left == 9'h000) // [RL3]
    else $error("zero start delay still counted");
  AST_POWERUP_STATE: assert property (ce && power_restore && !reg_wr && !peer_cfg_valid
                                      |=> q_reg.tx_en == $past(q_reg.powerup_state)) // [RL4]
    else $error("power-up state not applied");
  AST_READ_CODE: assert property (ce && reg_rd && (reg_addr == TX_ENABLE_OFF)
    |=> reg_rdata == {30'h0, !$past(q_reg.tx_en) ? TX_OFF : ($past(q_reg.tx_on) ? TX_ON : TX_MUTED)}) // [RL6]
    else $error("enable read code wrong");
  AST_OVERTEMP: assert property (ce && q_reg.ote && (temp_c > OVERTEMP_LIMIT_C) |=> !tx_output_on) // [RL7]
    else $error("output live above temperature limit");
  AST_WARM_STANDBY: assert property (ce && warm_off |=> !tx_output_on) // [RL17]
    else $error("warm standby unit transmitting");
  AST_RANGE_REJECT: assert property (ce && reg_wr && (reg_addr == ATTEN_OFF) && (reg_wdata > {24'h0, ATTEN_MAX})
                                     |=> cmd_reject && $stable(q_reg.atten)) // [RL24]
    else $error("bad attenuation write not rejected");
  AST_SLAVE_SHARED: assert property (ce && reg_wr && (reg_addr == REVERT_MODE_OFF) && q_reg.redund_en && !online
                                     && !peer_cfg_valid |=> cmd_reject && $stable(q_reg.revert)) // [RL15]
    else $error("offline unit accepted shared setting");
  AST_MANUAL_HOLD: assert property (ce && (q_reg.sw_type == SW_MANUAL)
                                    && !(reg_wr && (reg_addr == ONLINE_SELECT_OFF)) |=> $stable(switch_drive_b)) // [RL18]
    else $error("manual mode switched without command");
  AST_NONREVERT_HOLD: assert property (ce && (q_reg.revert == NON_REVERTING) && q_reg.switch_b
                                       && !(reg_wr && (reg_addr == ONLINE_SELECT_OFF)) |=> switch_drive_b) // [RL13]
    else $error("non-reverting pair left B side");
  AST_AUTO_SWITCH: assert property (ce && q_reg.redund_en && (q_reg.sw_type == SW_AUTO) && online_fault
                                    && !standby_fault && (q_reg.revert == REVERTING) && !reg_wr
                                    |=> switch_drive_b != $past(switch_drive_b)) // [RL19] [RL12]
    else $error("automatic switch missed");

endmodule // tx_output_redundancy_control

// File: tx_peer_model.sv
// Behavioural partner unit of the redundant pair
`timescale 1ns/1ns
module tx_peer_model
  import tx_redund_pkg::*;
(
  input wire logic clk,
  input wire logic fault,
  input wire logic push,
  output logic peer_major_fault_pin,
  output logic peer_cfg_valid,
  output clone_msg_t peer_cfg
);
  // ----------------------------------------------------------------
  // Online master pushing shared and cloned settings
  // ----------------------------------------------------------------
  localparam clone_msg_t MSG = '{REVERTING, SW_AUTO, 1'b0, 1'b1, 1'b1, 9'h005, 1'b1, 1'b1, 1'b1};
  always @(posedge clk) begin
    peer_major_fault_pin <= fault;
    peer_cfg_valid <= push;
    // Idle bus shows the inverse so a stale word never passes for a valid one
    peer_cfg <= push ? MSG : ~MSG;
  end
endmodule // tx_peer_model

// File: test_tx_output_redundancy_control.sv
// Self-checking testbench of the transmit redundancy controller
`timescale 1ns/1ns
module test_tx_output_redundancy_control
  import tx_redund_pkg::*;
;
  logic clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, lf = 0, pf = 0, pr = 0, push = 0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, v;
  logic signed [7:0] temp_c = 8'sh19;
  logic pcv, pfp, on, rej, swb, rd_d = 0, wr_d = 0;
  clone_msg_t pcfg, cmsg;
  clone_msg_t cq[$];
  logic mt, cv;
  logic [31:0] pa, ppa;
  int err_total = 0, checked = 0, seed = 32'hc16e5c80;
  logic [31:0] rdq[$];
  logic rjq[$];
  always #2 clk = ~clk;
  tx_peer_model peer (.clk(clk), .fault(pf), .push(push), .peer_major_fault_pin(pfp),
    .peer_cfg_valid(pcv), .peer_cfg(pcfg));
  tx_output_redundancy_control #(.CYCLES_PER_SEC_P(8)) uut (.clk(clk), .arst_n(arst_n), .ce(1'b1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .temp_c(temp_c), .local_major_fault(lf), .peer_major_fault_pin(pfp), .power_restore(pr),
    .peer_cfg_valid(pcv), .peer_cfg(pcfg), .tx_output_on(on), .tx_muted(mt), .switch_drive_b(swb),
    .clone_valid(cv), .clone_msg(cmsg), .peer_address(pa), .peer_public_address(ppa), .cmd_reject(rej));
  // ----------------------------------------------------------------
  // Bus tasks and comparisons
  // ----------------------------------------------------------------
  task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d, logic rj);
    @(posedge clk) begin reg_addr <= a; reg_wdata <= d; reg_wr <= 1; rjq.push_back(rj); end
    @(posedge clk) reg_wr <= 0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge clk) begin reg_addr <= a; reg_rd <= 1; rdq.push_back(e); end
    @(posedge clk) reg_rd <= 0;
  endtask
  task automatic idle(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic print_verdict;
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Results appear one cycle after the strobe; judge them mid-cycle
  always @(posedge clk) begin
    rd_d <= reg_rd;
    wr_d <= reg_wr;
  end
  always @(negedge clk) begin
    if (rd_d) cmp("rdata", rdq.pop_front(), reg_rdata);
    if (wr_d) cmp("reject", {31'h0, rjq.pop_front()}, {31'h0, rej});
    if (cv && cq.size() > 0) cmp("clone", {15'h0, cq.pop_front()}, {15'h0, cmsg});
  end
  initial begin
    #(4 * 40000);
    err_total++;
    print_verdict;
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    idle(12);
    arst_n <= 1;
    rd(ATTEN_OFF, 32'h0);
    rd(START_DELAY_OFF, 32'h0);
    rd(POWERUP_STATE_OFF, 32'h1);
    rd(TX_ENABLE_OFF, 32'h1);
    rd(OVERTEMP_EN_OFF, 32'h1);
    rd(PEER_ADDR_OFF, 32'hc0a80116);
    rd(SWITCH_TYPE_OFF, 32'h1);
    rd(REVERT_MODE_OFF, 32'h0);
    rd(REDUND_REPORT_OFF, 32'h2);
    rd(TX_HOURS_OFF, 32'h0);
    $display("test reset done");
    wr(ATTEN_OFF, 32'ha0, 0);
    wr(ATTEN_OFF, 32'ha1, 1);
    rd(ATTEN_OFF, 32'ha0);
    repeat (4) begin
      v = $unsigned($random(seed)) % 161;
      wr(ATTEN_OFF, v, 0);
      rd(ATTEN_OFF, v);
    end
    wr(TZ_OFFSET_OFF, 32'hf43b, 0);
    wr(TZ_OFFSET_OFF, 32'hf300, 1);
    rd(TZ_OFFSET_OFF, 32'hf43b);
    wr(PEER_ADDR_OFF, 32'he0000000, 1);
    wr(PEER_ADDR_OFF, 32'h01000000, 0);
    @(negedge clk) cmp("peer", 32'h01000000, pa);
    wr(PEER_PUBLIC_OFF, 32'h0a000001, 0);
    @(negedge clk) cmp("public", 32'h0a000001, ppa);
    wr(TX_HOURS_OFF, 32'h5, 1);
    wr(START_DELAY_OFF, 32'h1f5, 1);
    $display("test ranges done");
    temp_c <= 8'sh56;
    idle(3);
    rd(TX_ENABLE_OFF, 32'h2);
    @(negedge clk) cmp("on", 32'h0, {31'h0, on});
    wr(OVERTEMP_EN_OFF, 32'h0, 0);
    idle(3);
    rd(TX_ENABLE_OFF, 32'h1);
    wr(TX_ENABLE_OFF, 32'h0, 0);
    idle(2);
    rd(TX_ENABLE_OFF, 32'h0);
    wr(POWERUP_STATE_OFF, 32'h1, 0);
    wr(START_DELAY_OFF, 32'h2, 0);
    @(posedge clk) pr <= 1;
    @(posedge clk) pr <= 0;
    idle(2);
    rd(TX_ENABLE_OFF, 32'h2);
    idle(40);
    rd(TX_ENABLE_OFF, 32'h1);
    $display("test gating done");
    wr(SWITCH_TYPE_OFF, 32'h0, 0);
    wr(ONLINE_SELECT_OFF, 32'h1, 0);
    @(negedge clk) cmp("switch", 32'h1, {31'h0, swb});
    wr(ONLINE_SELECT_OFF, 32'h0, 0);
    wr(SWITCH_TYPE_OFF, 32'h1, 0);
    wr(REDUND_EN_OFF, 32'h1, 0);
    lf <= 1;
    idle(8);
    @(negedge clk) cmp("switch", 32'h1, {31'h0, swb});
    rd(PAIR_STATUS_OFF, 32'h1d);
    wr(REVERT_MODE_OFF, 32'h1, 1);
    @(posedge clk) push <= 1;
    @(posedge clk) push <= 0;
    idle(2);
    rd(START_DELAY_OFF, 32'h5);
    wr(START_DELAY_OFF, 32'h1, 1);
    lf <= 0;
    temp_c <= 8'sh19;
    cq.push_back(clone_msg_t'{REVERTING, SW_AUTO, 1'b0, 1'b1, 1'b1, 9'h005, 1'b1, 1'b1, 1'b1});
    wr(ONLINE_SELECT_OFF, 32'h0, 0);
    idle(90);
    cmp("clone sent", 32'h0, cq.size());
    wr(WARM_STANDBY_OFF, 32'h1, 0);
    wr(SWITCH_PORT_OFF, 32'h1, 0);
    idle(2);
    rd(TX_ENABLE_OFF, 32'h2);
    @(negedge clk) cmp("muted", 32'h1, {31'h0, mt});
    @(posedge clk) pf <= 1;
    idle(10);
    @(negedge clk) cmp("switch", 32'h1, {31'h0, swb});
    rd(TX_ENABLE_OFF, 32'h1);
    @(negedge clk) cmp("on", 32'h1, {31'h0, on});
    // One hour of live output at the shortened second
    idle(29000);
    rd(TX_HOURS_OFF, 32'h1);
    $display("test redundancy done");
    print_verdict;
  end
endmodule // test_tx_output_redundancy_control
